// File: src/sensor_diagnostic_monitor.sv
// Diagnostic supervisor: output overload protection, fault flags,
// ECC on limit words, transmitter oscillator frequency check.
// Assumes raw fault pins are asynchronous; host clears arrive as pulses.
`timescale 1ns/1ns
module sensor_diagnostic_monitor #(
    parameter int RETRIES = diag_pkg::OVL_RETRY_MAX
) (
    input  wire logic                   clock,          // 100 MHz
    input  wire logic                   rst_b,          // Power-on reset
    input  wire diag_pkg::pins_t        pinsRaw,        // Async faults
    input  wire logic                   digitalFault,   // Same clock
    input  wire logic                   bistDone,       // Self-test done
    input  wire logic                   bistFail,       // Self-test fail
    input  wire logic [diag_pkg::LIM_CW-1:0] loLimitCode, // Lower limit
    input  wire logic [diag_pkg::LIM_CW-1:0] hiLimitCode, // Upper limit
    input  wire diag_pkg::staticFlags_t staticClr,      // Host clears
    output diag_pkg::flags_t            flags,          // All flags
    output logic                        analogOutputsOff, // Tri-state
    output logic [diag_pkg::LIM_W-1:0]  oscMeasure,     // Edges/window
    output logic                        alarmInterrupt_b // Alarm, low
);
    import diag_pkg::*;

    if (RETRIES < 1 || RETRIES >= (1 << RETRY_W)) begin : g_chk
        $error("sensor_diagnostic_monitor: RETRIES out of range");
    end
    if (OVL_ASSERT_CYC > OVL_RELEASE_CYC) begin : g_chk2
        $error("sensor_diagnostic_monitor: timer too narrow");
    end

    typedef struct packed {
        logic [PIN_W-1:0]   s1;
        logic [PIN_W-1:0]   s2;
        logic [PIN_W-1:0]   s3;
        logic [PIN_W-1:0]   filt;
        ovlState_t          ovl;
        logic [TMR_W-1:0]   timer;
        logic [RETRY_W-1:0] retries;
        logic               outputsOff;
        logic [WIN_W-1:0]   winCnt;
        logic [LIM_W-1:0]   edgeCnt;
        logic [LIM_W-1:0]   meas;
        logic               measValid;
        logic               oscPrev;
        logic               bistSeen;
        flags_t             flags;
        logic               alarm_b;
    } state_t;

    state_t           st_r;
    state_t           st_nxt;
    logic [LIM_W-1:0] loLimit;
    logic [LIM_W-1:0] hiLimit;
    logic [1:0]       eccSingle;
    logic [1:0]       eccDouble;
    pins_t            filtPins;

    // Limit words live in protected storage
    ecc_secded #(.DATA_W(LIM_W), .PAR_W(LIM_PAR_W)) u_eccLo (
        .codeIn    (loLimitCode),
        .dataOut   (loLimit),
        .singleErr (eccSingle[0]),
        .doubleErr (eccDouble[0])
    );
    ecc_secded #(.DATA_W(LIM_W), .PAR_W(LIM_PAR_W)) u_eccHi (
        .codeIn    (hiLimitCode),
        .dataOut   (hiLimit),
        .singleErr (eccSingle[1]),
        .doubleErr (eccDouble[1])
    );

    always_comb begin
        pins_t        pin;
        staticFlags_t statSet;
        logic         txEdge;
        st_nxt  = st_r;
        pin     = pins_t'(st_r.filt);
        statSet = '0;
        txEdge  = pin.txOsc & ~st_r.oscPrev;

        // Three-stage sync; accept a change once stages two and three agree
        st_nxt.s1 = pinsRaw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < PIN_W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.filt[i] = st_r.s3[i];
            end
        end

        unique case (st_r.ovl)
            OVL_RUN: begin
                st_nxt.timer = '0;
                if (pin.overload) begin
                    st_nxt.ovl = OVL_DEBOUNCE;
                end
            end
            OVL_DEBOUNCE: begin
                if (!pin.overload) begin
                    st_nxt.ovl = OVL_RUN;
                end else if (st_r.timer == TMR_W'(OVL_ASSERT_CYC - 1)) begin
                    st_nxt.ovl        = OVL_OFF;
                    st_nxt.outputsOff = 1'b1;
                    st_nxt.timer      = '0;
                end else begin
                    st_nxt.timer = st_r.timer + 1'b1;
                end
            end
            OVL_OFF: begin
                if (st_r.timer == TMR_W'(OVL_RELEASE_CYC - 1)) begin
                    st_nxt.ovl        = OVL_RETRY;
                    st_nxt.outputsOff = 1'b0;
                    st_nxt.timer      = '0;
                end else begin
                    st_nxt.timer = st_r.timer + 1'b1;
                end
            end
            OVL_RETRY: begin
                // A retry passes as soon as the overload is gone
                if (!pin.overload) begin
                    st_nxt.ovl     = OVL_RUN;
                    st_nxt.retries = '0;
                end else if (st_r.timer == TMR_W'(OVL_ASSERT_CYC - 1)) begin
                    st_nxt.outputsOff = 1'b1;
                    st_nxt.timer      = '0;
                    if (st_r.retries == RETRY_W'(RETRIES - 1)) begin
                        st_nxt.ovl  = OVL_SHUTDOWN;
                        statSet.ovl = 1'b1;
                    end else begin
                        st_nxt.ovl     = OVL_OFF;
                        st_nxt.retries = st_r.retries + 1'b1;
                    end
                end else begin
                    st_nxt.timer = st_r.timer + 1'b1;
                end
            end
            OVL_SHUTDOWN: begin
                // Stays off to avoid heating; only a host clear leaves
                if (staticClr.ovl) begin
                    st_nxt.ovl        = OVL_RUN;
                    st_nxt.outputsOff = 1'b0;
                    st_nxt.retries    = '0;
                end
            end
        endcase

        // Frequency as edge count per fixed gate window
        st_nxt.oscPrev = pin.txOsc;
        st_nxt.winCnt  = st_r.winCnt + 1'b1;
        st_nxt.edgeCnt = st_r.edgeCnt + LIM_W'(txEdge);
        if (st_r.winCnt == WIN_W'(MEAS_WIN_CYC - 1)) begin
            st_nxt.meas      = st_r.edgeCnt + LIM_W'(txEdge);
            st_nxt.measValid = 1'b1;
            st_nxt.edgeCnt   = '0;
        end

        st_nxt.flags.temp.ovl        = pin.overload;
        st_nxt.flags.temp.rxCoil     = pin.rxCoil;
        st_nxt.flags.temp.txCoil     = pin.txCoil;
        st_nxt.flags.temp.junction   = pin.junction;
        st_nxt.flags.temp.agc        = pin.agcLimit;
        st_nxt.flags.temp.eccSingle  = |eccSingle;
        st_nxt.flags.temp.oscRange   = st_nxt.measValid &&
            (st_nxt.meas < loLimit || st_nxt.meas > hiLimit);
        st_nxt.flags.temp.oscStopped = st_nxt.measValid &&
            (st_nxt.meas == '0);

        statSet.supply    = pin.supply;
        statSet.digital   = digitalFault;
        statSet.intOsc    = pin.intOsc;
        statSet.eccDouble = |eccDouble;
        // Self-test outcome counts only on its first completion
        statSet.bist      = bistDone & bistFail & ~st_r.bistSeen;
        st_nxt.bistSeen   = st_r.bistSeen | bistDone;
        // Set wins over a clear in the same cycle
        st_nxt.flags.stat = (st_r.flags.stat & ~staticClr) | statSet;
        st_nxt.alarm_b    = ~|st_nxt.flags;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r         <= '0;
            st_r.alarm_b <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags            = st_r.flags;
    assign analogOutputsOff = st_r.outputsOff;
    assign oscMeasure       = st_r.meas;
    assign alarmInterrupt_b = st_r.alarm_b;
    assign filtPins         = st_r.filt;

    // Helper counters for the checks below
    logic [HELD_W-1:0] ovlHeld_r;
    logic [TMR_W-1:0]  offCnt_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ovlHeld_r <= '0;
            offCnt_r  <= '0;
        end else begin
            if (!filtPins.overload || st_r.outputsOff) begin
                ovlHeld_r <= '0;
            end else if (ovlHeld_r != '1) begin
                ovlHeld_r <= ovlHeld_r + 1'b1;
            end
            if (!st_r.outputsOff) begin
                offCnt_r <= '0;
            end else if (offCnt_r != '1) begin
                offCnt_r <= offCnt_r + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_ovlFollow;
        1 |=> st_r.flags.temp.ovl == $past(filtPins.overload);
    endproperty
    a_ovlFollow: assert property (p_ovlFollow)
        else $error("overload flag does not follow the condition");

    property p_offAfterHold;
        $rose(st_r.outputsOff) |->
            $past(ovlHeld_r) >= HELD_W'(OVL_ASSERT_CYC - 1);
    endproperty
    a_offAfterHold: assert property (p_offAfterHold)
        else $error("outputs switched off before debounce elapsed");

    property p_releaseTime;
        $fell(st_r.outputsOff) && $past(st_r.ovl) == OVL_OFF |->
            $past(offCnt_r) == TMR_W'(OVL_RELEASE_CYC - 1);
    endproperty
    a_releaseTime: assert property (p_releaseTime)
        else $error("retry started at the wrong time");

    property p_shutdownCount;
        $rose(st_r.flags.stat.ovl) |->
            $past(st_r.retries) == RETRY_W'(RETRIES - 1) &&
            st_r.outputsOff && st_r.ovl == OVL_SHUTDOWN;
    endproperty
    a_shutdownCount: assert property (p_shutdownCount)
        else $error("shutdown latched after wrong retry count");

    sequence s_inShutdown;
        st_r.ovl == OVL_SHUTDOWN && !staticClr.ovl;
    endsequence
    property p_shutdownHold;
        s_inShutdown |=> st_r.outputsOff && st_r.flags.stat.ovl;
    endproperty
    a_shutdownHold: assert property (p_shutdownHold)
        else $error("shutdown released without a clear");

    property p_agcFollow;
        1 |=> st_r.flags.temp.agc == $past(filtPins.agcLimit);
    endproperty
    a_agcFollow: assert property (p_agcFollow)
        else $error("gain limit flag does not follow the condition");

    property p_supplySet;
        filtPins.supply |=> st_r.flags.stat.supply;
    endproperty
    a_supplySet: assert property (p_supplySet)
        else $error("supply fault not latched");

    property p_staticHold;
        st_r.flags.stat.digital && !staticClr.digital |=>
            st_r.flags.stat.digital;
    endproperty
    a_staticHold: assert property (p_staticHold)
        else $error("static flag dropped without a clear");

    property p_bistOnce;
        $rose(st_r.flags.stat.bist) |->
            !$past(st_r.bistSeen) && $past(bistDone) && $past(bistFail);
    endproperty
    a_bistOnce: assert property (p_bistOnce)
        else $error("self-test flag set outside start-up");

    property p_eccAlarm;
        (|eccDouble) |=> st_r.flags.stat.eccDouble && !st_r.alarm_b;
    endproperty
    a_eccAlarm: assert property (p_eccAlarm)
        else $error("double-bit error did not raise alarm");

    property p_oscRange;
        st_r.measValid && $past(st_r.winCnt) == WIN_W'(MEAS_WIN_CYC - 1)
            |-> st_r.flags.temp.oscRange ==
            (st_r.meas < $past(loLimit) || st_r.meas > $past(hiLimit));
    endproperty
    a_oscRange: assert property (p_oscRange)
        else $error("oscillator range flag wrong");

    property p_alarm;
        1 |-> st_r.alarm_b == ~|st_r.flags;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm output disagrees with flags");

    property p_coilFollow;
        1 |=> st_r.flags.temp.rxCoil == $past(filtPins.rxCoil) &&
            st_r.flags.temp.txCoil == $past(filtPins.txCoil);
    endproperty
    a_coilFollow: assert property (p_coilFollow)
        else $error("coil fault flags do not follow the condition");

    property p_junctionFollow;
        1 |=> st_r.flags.temp.junction == $past(filtPins.junction);
    endproperty
    a_junctionFollow: assert property (p_junctionFollow)
        else $error("temperature flag does not follow the condition");

    property p_digitalSet;
        digitalFault |=> st_r.flags.stat.digital;
    endproperty
    a_digitalSet: assert property (p_digitalSet)
        else $error("digital fault not latched");

    property p_intOscSet;
        filtPins.intOsc |=> st_r.flags.stat.intOsc && !st_r.alarm_b;
    endproperty
    a_intOscSet: assert property (p_intOscSet)
        else $error("internal oscillator fault not latched");

    property p_eccSingle;
        (|eccSingle) |=> st_r.flags.temp.eccSingle;
    endproperty
    a_eccSingle: assert property (p_eccSingle)
        else $error("single-bit error not flagged");
endmodule

// File: shared/diag_pkg.sv
// Constants and carrier types for the sensor diagnostic monitor.
// Assumes a single 100 MHz clock domain; raw pins are asynchronous.
package diag_pkg;
    localparam int CLK_PERIOD_NS   = 10;
    // Debounce times, least times, rounded up to whole cycles
    localparam int OVL_ASSERT_NS   = 2000;
    localparam int OVL_RELEASE_NS  = 10000;
    localparam int OVL_ASSERT_CYC  =
        (OVL_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVL_RELEASE_CYC =
        (OVL_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W           = $clog2(OVL_RELEASE_CYC + 1);
    localparam int OVL_RETRY_MAX   = 8;
    localparam int RETRY_W         = 4;
    // Oscillator gate window in clock cycles
    localparam int MEAS_WIN_CYC    = 1024;
    localparam int WIN_W           = $clog2(MEAS_WIN_CYC);
    localparam int LIM_W           = 8;
    localparam int LIM_PAR_W       = 4;
    localparam int LIM_CW          = LIM_W + LIM_PAR_W + 1;
    localparam int HELD_W          = 12;

    // Asynchronous fault inputs, all active high
    typedef struct packed {
        logic rxCoil;
        logic txCoil;
        logic junction;
        logic supply;
        logic agcLimit;
        logic intOsc;
        logic overload;
        logic txOsc;
    } pins_t;
    localparam int PIN_W = $bits(pins_t);

    typedef struct packed {
        logic ovl;
        logic rxCoil;
        logic txCoil;
        logic junction;
        logic agc;
        logic eccSingle;
        logic oscRange;
        logic oscStopped;
    } tempFlags_t;

    typedef struct packed {
        logic ovl;
        logic supply;
        logic digital;
        logic bist;
        logic eccDouble;
        logic intOsc;
    } staticFlags_t;

    typedef struct packed {
        tempFlags_t   temp;
        staticFlags_t stat;
    } flags_t;

    typedef enum logic [2:0] {
        OVL_RUN,
        OVL_DEBOUNCE,
        OVL_OFF,
        OVL_RETRY,
        OVL_SHUTDOWN
    } ovlState_t;
endpackage

// File: src/ecc_secded.sv
// Single-error-correct, double-error-detect check of one stored word.
// Assumes Hamming layout: bit 0 overall even parity, parity at 2^k.
`timescale 1ns/1ns
module ecc_secded #(
    parameter int DATA_W = 8,
    parameter int PAR_W  = 4
) (
    input  wire logic [DATA_W+PAR_W:0] codeIn,    // Stored codeword
    output logic      [DATA_W-1:0]     dataOut,   // Corrected data
    output logic                       singleErr, // Corrected error
    output logic                       doubleErr  // Uncorrectable
);
    localparam int N = DATA_W + PAR_W;

    if ((1 << PAR_W) < N + 1) begin : g_chk
        $error("ecc_secded: too few parity bits");
    end

    always_comb begin
        logic [PAR_W-1:0] syn;
        logic [N:0]       fixed;
        logic             par;
        int               k;
        syn   = '0;
        fixed = codeIn;
        par   = ^codeIn;
        k     = 0;
        for (int i = 1; i <= N; i++) begin
            if (codeIn[i]) begin
                syn = syn ^ PAR_W'(i);
            end
        end
        // Odd overall parity: one flipped bit, syndrome points at it
        if (par && int'(syn) <= N) begin
            fixed[syn] = ~fixed[syn];
        end
        singleErr = par;
        doubleErr = ~par && (syn != '0);
        dataOut   = '0;
        for (int i = 1; i <= N; i++) begin
            if ((i & (i - 1)) != 0) begin
                dataOut[k] = fixed[i];
                k = k + 1;
            end
        end
    end
endmodule

// File: tb/host_model.sv
// Host side of the diagnostic link: turns clear requests into strobes.
// Assumes the bench holds each request level for at least one clock cycle.
`timescale 1ns/1ns
module host_model (
    input  wire logic                   clock,     // System clock
    input  wire logic                   rst_b,     // Reset, active low
    input  wire diag_pkg::staticFlags_t clrReq,    // Bench request level
    output diag_pkg::staticFlags_t      staticClr  // One-cycle clears
);
    import diag_pkg::*;
    staticFlags_t reqSeen_r;
    // A held level would clear every cycle; the host only sends pulses
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reqSeen_r <= '0;
            staticClr <= '0;
        end else begin
            reqSeen_r <= clrReq;
            staticClr <= clrReq & ~reqSeen_r;
        end
    end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the sensor diagnostic monitor.
// Assumes one 100 MHz clock; host clears come through host_model.
`timescale 1ns/1ns
module tb_top;
    import diag_pkg::*;
    localparam int RETRY_N = OVL_RETRY_MAX;
    logic              clock;
    logic              rst_b;
    logic [7:1]        pinLvl;
    logic              oscWave;
    logic              oscRun;
    pins_t             pinsRaw;
    logic              digitalFault;
    logic              bistDone;
    logic              bistFail;
    logic [LIM_CW-1:0] loLimitCode;
    logic [LIM_CW-1:0] hiLimitCode;
    staticFlags_t      clrReq;
    staticFlags_t      staticClr;
    flags_t            flags;
    logic              analogOutputsOff;
    logic [LIM_W-1:0]  oscMeasure;
    logic              alarmInterrupt_b;
    int                nMismatch;
    int                samplesChecked;

    assign pinsRaw = pins_t'({pinLvl, oscWave});

    sensor_diagnostic_monitor #(.RETRIES(RETRY_N))
        i_sensor_diagnostic_monitor (
        .clock(clock), .rst_b(rst_b), .pinsRaw(pinsRaw),
        .digitalFault(digitalFault), .bistDone(bistDone),
        .bistFail(bistFail), .loLimitCode(loLimitCode),
        .hiLimitCode(hiLimitCode), .staticClr(staticClr), .flags(flags),
        .analogOutputsOff(analogOutputsOff), .oscMeasure(oscMeasure),
        .alarmInterrupt_b(alarmInterrupt_b));

    host_model i_host_model (
        .clock(clock), .rst_b(rst_b), .clrReq(clrReq),
        .staticClr(staticClr));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Transmitter oscillator: 80 ns period gives 128 edges per window
    initial begin
        oscWave = 1'b0;
        #6;
        forever begin
            #40;
            oscWave = oscRun ? ~oscWave : 1'b0;
        end
    end

    function automatic logic [12:0] enc(input logic [7:0] d);
        logic [12:0] c;
        int pos[8] = '{3, 5, 6, 7, 9, 10, 11, 12};
        c = '0;
        for (int i = 0; i < 8; i++) c[pos[i]] = d[i];
        for (int k = 0; k < 4; k++)
            for (int j = 1; j < 13; j++)
                if ((j & (1 << k)) != 0) c[1 << k] ^= c[j];
        c[0] = ^c[12:1];
        return c;
    endfunction

    task automatic wrapUp();
        if (nMismatch == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic hostClear(input logic [5:0] mask);
        clrReq = staticFlags_t'(mask);
        cyc(1);
        clrReq = '0;
        cyc(3);
    endtask

    task automatic tempPins();
        int pinIdx[4] = '{7, 6, 5, 3};
        int flagIdx[4] = '{6, 5, 4, 3};
        for (int i = 0; i < 4; i++) begin
            pinLvl[pinIdx[i]] = 1'b1;
            cyc(6);
            chk("tempSet", 16'h0001 << flagIdx[i], flags.temp);
            chk("alarmLow", 16'h0000, alarmInterrupt_b);
            pinLvl[pinIdx[i]] = 1'b0;
            cyc(6);
            chk("tempFollow", 16'h0000, flags.temp);
            chk("alarmHigh", 16'h0001, alarmInterrupt_b);
        end
    endtask

    task automatic staticPins();
        int pinIdx[2] = '{4, 2};
        int flagIdx[2] = '{4, 0};
        for (int i = 0; i < 2; i++) begin
            pinLvl[pinIdx[i]] = 1'b1;
            cyc(6);
            hostClear(6'h01 << flagIdx[i]);
            chk("setWins", 16'h0001 << flagIdx[i], flags.stat);
            pinLvl[pinIdx[i]] = 1'b0;
            cyc(8);
            chk("statLatch", 16'h0001 << flagIdx[i], flags.stat);
            hostClear(6'h01 << flagIdx[i]);
            chk("statClear", 16'h0000, flags.stat);
            chk("alarmHigh", 16'h0001, alarmInterrupt_b);
        end
    endtask

    task automatic digitalAndBist();
        digitalFault = 1'b1;
        cyc(1);
        digitalFault = 1'b0;
        cyc(3);
        chk("digital", 16'h0008, flags.stat);
        hostClear(6'h08);
        bistDone = 1'b1;
        bistFail = 1'b1;
        cyc(1);
        bistDone = 1'b0;
        cyc(3);
        chk("bistFirst", 16'h0004, flags.stat);
        hostClear(6'h04);
        bistDone = 1'b1;
        cyc(3);
        chk("bistLater", 16'h0000, flags.stat);
        bistDone = 1'b0;
        bistFail = 1'b0;
    endtask

    task automatic eccWords();
        loLimitCode = enc(8'h00) ^ 13'h0008;
        cyc(2);
        chk("eccSingleLo", 16'h0004, flags.temp);
        loLimitCode = enc(8'h00);
        hiLimitCode = enc(8'hFF) ^ 13'h0100;
        cyc(2);
        chk("eccSingleHi", 16'h0004, flags.temp);
        hiLimitCode = enc(8'hFF);
        cyc(2);
        chk("eccGone", 16'h0000, flags.temp);
        loLimitCode = enc(8'h00) ^ 13'h0018;
        cyc(2);
        chk("eccDouble", 16'h0002, flags.stat);
        chk("alarmLow", 16'h0000, alarmInterrupt_b);
        loLimitCode = enc(8'h00);
        hostClear(6'h02);
        chk("eccCleared", 16'h0000, flags.stat);
    endtask

    task automatic oscCheck();
        logic inWin;
        // Flipped top data bit: only the corrected lower limit passes 128
        loLimitCode = enc(8'h78) ^ 13'h1000;
        hiLimitCode = enc(8'h88);
        cyc(2100);
        inWin = oscMeasure >= 8'h7E && oscMeasure <= 8'h82;
        chk("oscMeasure", 16'h0001, inWin);
        chk("inRange", 16'h0004, flags.temp);
        hiLimitCode = enc(8'h70);
        cyc(2100);
        chk("aboveHigh", 16'h0006, flags.temp);
        loLimitCode = enc(8'h90);
        hiLimitCode = enc(8'hFF);
        cyc(2100);
        chk("belowLow", 16'h0002, flags.temp);
        loLimitCode = enc(8'h00);
        oscRun = 1'b0;
        cyc(2100);
        chk("oscZero", 16'h0000, oscMeasure);
        chk("oscStopped", 16'h0001, flags.temp);
        oscRun = 1'b1;
        cyc(2100);
        chk("oscBack", 16'h0000, flags.temp);
    endtask

    task automatic overload();
        pinLvl[1] = 1'b1;
        cyc(100);
        chk("ovlTemp", 16'h0080, flags.temp);
        pinLvl[1] = 1'b0;
        cyc(150);
        chk("shortGlitch", 16'h0000, analogOutputsOff);
        pinLvl[1] = 1'b1;
        cyc(195);
        chk("beforeDebounce", 16'h0000, analogOutputsOff);
        cyc(15);
        chk("afterDebounce", 16'h0001, analogOutputsOff);
        cyc(985);
        chk("releaseHold", 16'h0001, analogOutputsOff);
        cyc(20);
        chk("retryOn", 16'h0000, analogOutputsOff);
        cyc(8485);
        chk("noEarlyLatch", 16'h0000, flags.stat);
        cyc(200);
        chk("shutLatch", 16'h0020, flags.stat);
        pinLvl[1] = 1'b0;
        cyc(1500);
        chk("shutHolds", 16'h0001, analogOutputsOff);
        hostClear(6'h20);
        chk("shutCleared", 16'h0000, analogOutputsOff);
        chk("flagCleared", 16'h0000, flags.stat);
        chk("alarmHigh", 16'h0001, alarmInterrupt_b);
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        nMismatch++;
        wrapUp();
    end

    initial begin
        nMismatch = 0;
        samplesChecked = 0;
        rst_b = 1'b0;
        pinLvl = '0;
        oscRun = 1'b1;
        digitalFault = 1'b0;
        bistDone = 1'b0;
        bistFail = 1'b0;
        loLimitCode = enc(8'h00);
        hiLimitCode = enc(8'hFF);
        clrReq = '0;
        cyc(20);
        chk("rstFlags", 16'h0000, flags);
        chk("rstOff", 16'h0000, analogOutputsOff);
        chk("rstAlarm", 16'h0001, alarmInterrupt_b);
        rst_b = 1'b1;
        cyc(1100);
        tempPins();
        staticPins();
        digitalAndBist();
        eccWords();
        oscCheck();
        overload();
        wrapUp();
    end
endmodule
